// >>> pkg/pwr_ctrl_pkg.sv
// Constants, register map and types of the power mode and sync clock controller.
// Assumes a 125 MHz core clock and an AHB-Lite master with 32-bit word accesses.
package pwr_ctrl_pkg;

  localparam int          NUM_PHY       = 4;
  localparam int          NUM_PORT      = 5;

  localparam logic [7:0]  A_PD_CTRL0    = 8'h00;
  localparam logic [7:0]  A_PORT_PD     = 8'h04;
  localparam logic [7:0]  A_EEE_EN      = 8'h08;
  localparam logic [7:0]  A_CLK_OUT     = 8'h0C;
  localparam logic [7:0]  A_ENERGY_DETECT_POWER_DOWN_TMO    = 8'h10;
  localparam logic [7:0]  A_STATUS      = 8'h14;
  localparam logic [7:0]  A_STRAP       = 8'h18;

  localparam int          MODE_LSB      = 3;
  localparam logic [1:0]  CODE_NORMAL   = 2'h0;
  localparam logic [1:0]  CODE_ENERGY_DETECT_POWER_DOWN     = 2'h1;
  localparam logic [1:0]  CODE_SOFTPD   = 2'h2;
  localparam int          CLK_EN_BIT    = 0;
  localparam int          CLK_125_BIT   = 1;
  localparam int          CLK_SRC_LSB   = 2;

  localparam logic [2:0]  SRC_REF       = 3'h0;
  localparam logic        CLK_EN_RST    = 1'b1;
  localparam logic        CLK_125_RST   = 1'b0;
  localparam logic [4:0]  PORT_PD_RST   = 5'h00;

  localparam int          CLK_PERIOD_PS = 8000;
  localparam int          ED_ON_NS      = 100;
  localparam int          ED_ON_CYC     = (ED_ON_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          LP_GAP_MS     = 16;
  localparam int          LP_GAP_CYC    = LP_GAP_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int          LP_LEN_CYC    = ED_ON_CYC;
  localparam int          ENERGY_DETECT_POWER_DOWN_TMO_MS   = 10;
  localparam int          ENERGY_DETECT_POWER_DOWN_TMO_CYC  = ENERGY_DETECT_POWER_DOWN_TMO_MS * (1000000000 / CLK_PERIOD_PS);
  localparam logic [2:0]  DIV_25M       = 3'h5;

  typedef enum logic [1:0] {PM_NORMAL, PM_ENERGY_DETECT_POWER_DOWN, PM_SOFTPD} pm_mode_t;
  typedef enum logic {ED_HIGH, ED_LOW} ed_state_t;

  typedef struct packed {
    pm_mode_t              mode;
    logic [NUM_PORT-1:0]   port_pd;
    logic [NUM_PHY-1:0]    eee_en;
    logic                  clk_en;
    logic                  clk_125;
    logic [2:0]            clk_src;
  } cfg_t;

endpackage

// >>> src/power_mode_and_sync_clock_ctrl.sv
// Global power mode control, per-port power down and low-power idle, sync clock output.
// Assumes an AHB-Lite master, synchronous inputs, and recovered clocks given as tick pulses.
`timescale 1ns/100ps
module power_mode_and_sync_clock_ctrl
  import pwr_ctrl_pkg::*;
#(
  parameter int unsigned LP_GAP   = LP_GAP_CYC,
  parameter int unsigned TMO_DEF  = ENERGY_DETECT_POWER_DOWN_TMO_CYC
)(
  input  wire logic                I_REF_CLK,
  input  wire logic                I_RST,
  input  wire logic                I_HSEL,
  input  wire logic [31:0]         I_HADDR,
  input  wire logic [1:0]          I_HTRANS,
  input  wire logic                I_HWRITE,
  input  wire logic [2:0]          I_HSIZE,
  input  wire logic [31:0]         I_HWDATA,
  input  wire logic                I_HREADY,
  output logic      [31:0]         O_HRDATA,
  output logic                     O_HREADYOUT,
  output logic                     O_HRESP,
  input  wire logic [NUM_PHY-1:0]  I_STRAP,
  input  wire logic [NUM_PHY-1:0]  I_CABLE_ENERGY,
  input  wire logic [NUM_PHY-1:0]  I_AN_OK,
  input  wire logic [NUM_PHY-1:0]  I_TX_IDLE_REQ,
  input  wire logic [NUM_PHY-1:0]  I_RX_IDLE_SEEN,
  input  wire logic [NUM_PHY-1:0]  I_RECOV_TICK,
  output logic                     O_SYNC_ETHERNET_CLOCK_OUT,
  output logic                     O_PLL_EN,
  output logic [NUM_PHY-1:0]       O_PHY_EN,
  output logic                     O_PHY_ED_ONLY,
  output logic                     O_MAC_EN,
  output logic                     O_HOST_IF_EN,
  output logic [NUM_PORT-1:0]      O_PORT_PD,
  output logic                     O_LINK_PULSE,
  output logic [NUM_PHY-1:0]       O_LPI_TX,
  output logic [NUM_PHY-1:0]       O_LPI_RX
);

  cfg_t                 cfg_ff;
  logic [31:0]          tmo_ff;
  logic [NUM_PHY-1:0]   strap_ff;
  logic                 strap_load_ff;
  ed_state_t            ed_ff;
  logic [31:0]          ed_cnt_ff;
  logic [31:0]          lp_cnt_ff;
  logic [2:0]           div_ff;
  logic                 wr_pend_ff;
  logic [7:0]           wr_addr_ff;

  // AHB-Lite slave with no wait states; it only answers, it never drives a
  // management clock of its own
  wire        addr_ok   = I_HSEL & I_HTRANS[1] & I_HREADY;
  wire [7:0]  a_addr    = I_HADDR[7:0];
  wire        wr_fire   = wr_pend_ff;
  wire [1:0]  wr_code   = I_HWDATA[MODE_LSB+1:MODE_LSB];
  wire        wr_mode   = wr_fire & (wr_addr_ff == A_PD_CTRL0);
  wire        code_ok   = wr_code != 2'h3;
  // Reserved code leaves the mode as it was
  wire pm_mode_t new_mode = (wr_code == CODE_ENERGY_DETECT_POWER_DOWN)   ? PM_ENERGY_DETECT_POWER_DOWN :
                            (wr_code == CODE_SOFTPD) ? PM_SOFTPD : PM_NORMAL;
  wire        sp_exit   = wr_mode & code_ok & (cfg_ff.mode == PM_SOFTPD) & (new_mode != PM_SOFTPD);
  wire [1:0]  mode_code = (cfg_ff.mode == PM_ENERGY_DETECT_POWER_DOWN) ? CODE_ENERGY_DETECT_POWER_DOWN :
                          (cfg_ff.mode == PM_SOFTPD) ? CODE_SOFTPD : CODE_NORMAL;

  wire [31:0] rd_word =
    (a_addr == A_PD_CTRL0) ? {27'h000_0000, mode_code, 3'h0} :
    (a_addr == A_PORT_PD)  ? {27'h000_0000, cfg_ff.port_pd} :
    (a_addr == A_EEE_EN)   ? {28'h000_0000, cfg_ff.eee_en} :
    (a_addr == A_CLK_OUT)  ? {27'h000_0000, cfg_ff.clk_src, cfg_ff.clk_125, cfg_ff.clk_en} :
    (a_addr == A_ENERGY_DETECT_POWER_DOWN_TMO) ? tmo_ff :
    (a_addr == A_STATUS)   ? {20'h0_0000, O_LPI_RX, O_LPI_TX, ed_ff == ED_LOW, mode_code, 1'b0} :
    (a_addr == A_STRAP)    ? {28'h000_0000, strap_ff} : 32'h0000_0000;

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      wr_pend_ff  <= 1'b0;
      wr_addr_ff  <= 8'h00;
      O_HRDATA    <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end
    else
    begin
      wr_pend_ff  <= addr_ok & I_HWRITE;
      wr_addr_ff  <= a_addr;
      O_HRDATA    <= (addr_ok & ~I_HWRITE) ? rd_word : 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end
  end

  // Straps are captured one edge after reset release or after soft power down ends
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
      strap_load_ff <= 1'b1;
    else
      strap_load_ff <= sp_exit;
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
      strap_ff <= '0;
    else if (strap_load_ff)
      strap_ff <= I_STRAP;
  end

  // Configuration bank; a write that leaves soft power down restores defaults
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      cfg_ff.mode    <= PM_NORMAL;
      cfg_ff.port_pd <= PORT_PD_RST;
      cfg_ff.eee_en  <= '0;
      cfg_ff.clk_en  <= CLK_EN_RST;
      cfg_ff.clk_125 <= CLK_125_RST;
      cfg_ff.clk_src <= SRC_REF;
      tmo_ff         <= TMO_DEF;
    end
    else if (sp_exit)
    begin
      cfg_ff.mode    <= new_mode;
      cfg_ff.port_pd <= PORT_PD_RST;
      cfg_ff.eee_en  <= '0;
      cfg_ff.clk_en  <= CLK_EN_RST;
      cfg_ff.clk_125 <= CLK_125_RST;
      cfg_ff.clk_src <= SRC_REF;
      tmo_ff         <= TMO_DEF;
    end
    else if (strap_load_ff)
      cfg_ff.eee_en <= I_STRAP;
    else if (wr_fire)
    begin
      // Any mode may be written from any mode, the enum holds just one
      if (wr_addr_ff == A_PD_CTRL0 && code_ok)
        cfg_ff.mode <= new_mode;
      else if (wr_addr_ff == A_PORT_PD)
        cfg_ff.port_pd <= I_HWDATA[NUM_PORT-1:0];
      else if (wr_addr_ff == A_EEE_EN)
        cfg_ff.eee_en <= I_HWDATA[NUM_PHY-1:0];
      else if (wr_addr_ff == A_CLK_OUT)
      begin
        cfg_ff.clk_en  <= I_HWDATA[CLK_EN_BIT];
        cfg_ff.clk_125 <= I_HWDATA[CLK_125_BIT];
        if (I_HWDATA[CLK_SRC_LSB+2:CLK_SRC_LSB] <= 3'(NUM_PHY))
          cfg_ff.clk_src <= I_HWDATA[CLK_SRC_LSB+2:CLK_SRC_LSB];
      end
      else if (wr_addr_ff == A_ENERGY_DETECT_POWER_DOWN_TMO)
        tmo_ff <= I_HWDATA;
    end
  end

  // Energy-detect sub-states; a reading of energy assumes auto-negotiation is on
  wire       energy   = |I_CABLE_ENERGY;
  wire       in_energy_detect_power_down  = cfg_ff.mode == PM_ENERGY_DETECT_POWER_DOWN;
  wire       go_low   = in_energy_detect_power_down & (ed_ff == ED_HIGH) & ~energy & (ed_cnt_ff >= tmo_ff);
  wire       go_high  = (ed_ff == ED_LOW) & (~in_energy_detect_power_down | (energy & (ed_cnt_ff >= 32'(ED_ON_CYC - 1))));

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      ed_ff     <= ED_HIGH;
      ed_cnt_ff <= 32'h0000_0000;
    end
    else if (go_low)
    begin
      ed_ff     <= ED_LOW;
      ed_cnt_ff <= 32'h0000_0000;
    end
    else if (go_high)
    begin
      ed_ff     <= ED_HIGH;
      ed_cnt_ff <= 32'h0000_0000;
    end
    else if (in_energy_detect_power_down & ((ed_ff == ED_HIGH) ^ energy))
      ed_cnt_ff <= ed_cnt_ff + 32'h0000_0001;
    else
      ed_cnt_ff <= 32'h0000_0000;
  end

  // Link pulses at a long gap and a short width, only in the low-power state
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST || ed_ff != ED_LOW || go_high)
    begin
      lp_cnt_ff    <= 32'h0000_0000;
      O_LINK_PULSE <= 1'b0;
    end
    else
    begin
      lp_cnt_ff    <= (lp_cnt_ff >= LP_GAP - 1) ? 32'h0000_0000 : lp_cnt_ff + 32'h0000_0001;
      O_LINK_PULSE <= lp_cnt_ff < 32'(LP_LEN_CYC);
    end
  end

  // Block enables per mode; in the low-power state the PHYs keep only energy detection
  wire on_norm  = cfg_ff.mode == PM_NORMAL;
  wire phy_run  = on_norm | (in_energy_detect_power_down & ed_ff == ED_HIGH);

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      O_PLL_EN      <= 1'b1;
      O_MAC_EN      <= 1'b1;
      O_HOST_IF_EN  <= 1'b1;
      O_PHY_EN      <= '1;
      O_PHY_ED_ONLY <= 1'b0;
      O_PORT_PD     <= PORT_PD_RST;
    end
    else
    begin
      O_PLL_EN      <= on_norm;
      O_MAC_EN      <= on_norm;
      O_HOST_IF_EN  <= on_norm;
      O_PHY_EN      <= {NUM_PHY{phy_run}} & ~cfg_ff.port_pd[NUM_PHY-1:0];
      O_PHY_ED_ONLY <= in_energy_detect_power_down;
      O_PORT_PD     <= cfg_ff.port_pd;
    end
  end

  // Low-power idle on PHY ports only; port5 has no such path at all
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PHY; gi++)
    begin : g_lpi
      wire ok = cfg_ff.eee_en[gi] & I_AN_OK[gi] & on_norm & ~cfg_ff.port_pd[gi];
      always_ff @(posedge I_REF_CLK)
      begin
        if (I_RST)
        begin
          O_LPI_TX[gi] <= 1'b0;
          O_LPI_RX[gi] <= 1'b0;
        end
        else
        begin
          O_LPI_TX[gi] <= ok & I_TX_IDLE_REQ[gi];
          O_LPI_RX[gi] <= ok & I_RX_IDLE_SEEN[gi];
        end
      end
    end
  endgenerate

  // Sync clock output: one tick per output period; the pad-side generator shapes it
  wire src_tick = (cfg_ff.clk_src == SRC_REF) ? 1'b1 :
                  I_RECOV_TICK[cfg_ff.clk_src[1:0] - 2'h1];
  wire clk_live = cfg_ff.clk_en & (cfg_ff.mode != PM_SOFTPD);

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST || !clk_live)
    begin
      div_ff                    <= 3'h0;
      O_SYNC_ETHERNET_CLOCK_OUT <= 1'b0;
    end
    else if (src_tick)
    begin
      div_ff                    <= (div_ff >= DIV_25M - 3'h1) ? 3'h0 : div_ff + 3'h1;
      O_SYNC_ETHERNET_CLOCK_OUT <= cfg_ff.clk_125 | (div_ff == 3'h0);
    end
    else
      O_SYNC_ETHERNET_CLOCK_OUT <= 1'b0;
  end

  sequence s_energy_13;
    (ed_ff == ED_LOW && energy && in_energy_detect_power_down)[*7] ##1 (ed_ff == ED_LOW && energy && in_energy_detect_power_down)[*6];
  endsequence

  a_softpd_all_off: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    cfg_ff.mode == PM_SOFTPD |=> !O_PLL_EN && !O_MAC_EN && !O_HOST_IF_EN && O_PHY_EN == '0
      && !O_SYNC_ETHERNET_CLOCK_OUT)
    else $error("soft power down left a block running");

  a_normal_all_on: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    on_norm |=> O_PLL_EN && O_MAC_EN && O_HOST_IF_EN && O_PHY_EN == ~$past(cfg_ff.port_pd[NUM_PHY-1:0]))
    else $error("normal mode enables wrong");

  a_ed_wake_time: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    s_energy_13 |=> ed_ff == ED_HIGH)
    else $error("no wake after energy held");

  a_ed_no_early: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    ed_ff == ED_LOW && in_energy_detect_power_down && !energy |=> ed_ff == ED_LOW)
    else $error("woke without energy");

  a_ed_stay_high: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    ed_ff == ED_HIGH && energy |=> ed_ff == ED_HIGH)
    else $error("went low with energy present");

  a_reserved_ignored: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    wr_mode && !code_ok && !strap_load_ff |=> cfg_ff.mode == $past(cfg_ff.mode))
    else $error("reserved mode code changed mode");

  a_softpd_exit_dflt: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    sp_exit |=> cfg_ff.clk_src == SRC_REF && cfg_ff.port_pd == PORT_PD_RST && strap_load_ff
      ##1 strap_ff == $past(I_STRAP))
    else $error("soft power down exit not to defaults");

  a_lpi_needs_an: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (O_LPI_TX | O_LPI_RX) != '0 |-> ((O_LPI_TX | O_LPI_RX) & ~$past(I_AN_OK & cfg_ff.eee_en)) == '0)
    else $error("idle without negotiation or enable");

  a_lpi_exit_fast: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (~I_TX_IDLE_REQ & ~I_RX_IDLE_SEEN) != '0 |=>
      ((O_LPI_TX | O_LPI_RX) & $past(~I_TX_IDLE_REQ & ~I_RX_IDLE_SEEN)) == '0)
    else $error("idle held after traffic resumed");

  a_sync_off: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    !cfg_ff.clk_en |=> !O_SYNC_ETHERNET_CLOCK_OUT)
    else $error("sync clock out while disabled");

endmodule

// >>> tb/link_partner_model.sv
// Cable link partner model: energy, negotiation result, idle signalling, recovered clocks.
// Assumes the bench commands each level; recovered ticks run free once reset is released.
`timescale 1ns/100ps
module link_partner_model
  import pwr_ctrl_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_energy,
  input  wire logic [NUM_PHY-1:0] i_an_ok,
  input  wire logic [NUM_PHY-1:0] i_tx_req,
  input  wire logic [NUM_PHY-1:0] i_rx_idle,
  output logic      [NUM_PHY-1:0] o_cable_energy,
  output logic      [NUM_PHY-1:0] o_an_ok,
  output logic      [NUM_PHY-1:0] o_tx_req,
  output logic      [NUM_PHY-1:0] o_rx_idle,
  output logic      [NUM_PHY-1:0] o_recov_tick
);
  logic [3:0] cnt_ff [NUM_PHY];

  assign o_cable_energy = {NUM_PHY{i_energy}};
  // Negotiation stays up while energy-detect mode is in use
  assign o_an_ok        = i_an_ok;
  assign o_tx_req       = i_tx_req;
  assign o_rx_idle      = i_rx_idle;

  // Port k recovers a clock of k+2 cycles, so each source gives its own rate
  always_ff @(posedge i_clk)
    for (int k = 0; k < NUM_PHY; k++)
    begin
      cnt_ff[k]       <= (i_rst || cnt_ff[k] == 4'(k + 1)) ? 4'h0 : cnt_ff[k] + 4'h1;
      o_recov_tick[k] <= !i_rst && cnt_ff[k] == 4'(k + 1);
    end
endmodule

// >>> tb/power_mode_and_sync_clock_ctrl_tb.sv
// Self-checking bench for the power mode and sync clock controller.
// Assumes zero-wait AHB-Lite answers and the shortened gap and timeout below.
`timescale 1ns/100ps
module power_mode_and_sync_clock_ctrl_tb;
  import pwr_ctrl_pkg::*;
  localparam int GAP = 50;
  localparam int TMO = 20;
  logic                clk, rst, hsel, hwrite, hready, hresp, sync_out, energy;
  logic                pll_en, ed_only, mac_en, host_en, link_pulse;
  logic [1:0]          htrans;
  logic [31:0]         haddr, hwdata, hrdata, dummy;
  logic [NUM_PHY-1:0]  strap, cab, an_ok, an_cmd, txr, txr_cmd, rxi, rxi_cmd, tick, phy_en, lpi_tx, lpi_rx;
  logic [NUM_PORT-1:0] port_pd;
  int                  err_count, checked;

  power_mode_and_sync_clock_ctrl #(.LP_GAP(GAP), .TMO_DEF(TMO)) DUT (
    .I_REF_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_STRAP(strap), .I_CABLE_ENERGY(cab), .I_AN_OK(an_ok),
    .I_TX_IDLE_REQ(txr), .I_RX_IDLE_SEEN(rxi), .I_RECOV_TICK(tick), .O_SYNC_ETHERNET_CLOCK_OUT(sync_out),
    .O_PLL_EN(pll_en), .O_PHY_EN(phy_en), .O_PHY_ED_ONLY(ed_only), .O_MAC_EN(mac_en),
    .O_HOST_IF_EN(host_en), .O_PORT_PD(port_pd), .O_LINK_PULSE(link_pulse), .O_LPI_TX(lpi_tx), .O_LPI_RX(lpi_rx));

  link_partner_model PARTNER (.i_clk(clk), .i_rst(rst), .i_energy(energy), .i_an_ok(an_cmd),
    .i_tx_req(txr_cmd), .i_rx_idle(rxi_cmd), .o_cable_energy(cab), .o_an_ok(an_ok),
    .o_tx_req(txr), .o_rx_idle(rxi), .o_recov_tick(tick));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim;
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Single word transfer; read data is taken at the edge that closes the data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wr ? d : 32'h0000_0000;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, dummy);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0000_0000, v);
    chk(nm, v, exp);
  endtask

  task automatic ticks(input string nm, input int exp);
    int n;
    n = 0;
    repeat (50)
    begin
      @(posedge clk);
      if (sync_out === 1'b1)
        n++;
    end
    chk(nm, 32'(n), 32'(exp));
  endtask

  // Divider and source switch are let settle before counting
  task automatic setclk(input logic [31:0] d, input string nm, input int exp);
    wr(A_CLK_OUT, d);
    cyc(12);
    ticks(nm, exp);
  endtask

  task automatic t_reset;
    chk("en_after_reset", {pll_en, mac_en, host_en, ed_only, phy_en}, 8'hEF);
    rdchk("status_reset", A_STATUS, 32'h0000_0000);
    rdchk("clk_reg_reset", A_CLK_OUT, 32'h0000_0001);
    rdchk("unmapped", 8'h1C, 32'h0000_0000);
    chk("hresp_okay", 32'(hresp), 32'h0000_0000);
  endtask

  task automatic t_clk;
    ticks("ref_25", 10);
    setclk(32'h0000_0003, "ref_125", 50);
    setclk(32'h0000_0007, "port1_125", 25);
    setclk(32'h0000_0005, "port1_25", 5);
    setclk(32'h0000_001F, "bad_src_kept", 25);
    setclk(32'h0000_0006, "disabled", 0);
    setclk(32'h0000_0001, "ref_again", 10);
  endtask

  task automatic t_energy_detect_power_down;
    int n;
    wr(A_PORT_PD, 32'h0000_0002);
    cyc(3);
    chk("phy_en_port_pd", {3'h0, port_pd, phy_en}, 12'h02D);
    wr(A_PD_CTRL0, 32'h0000_0008);
    cyc(3);
    chk("energy_detect_power_down_enables", {pll_en, mac_en, host_en, ed_only, phy_en}, 8'h1D);
    rdchk("status_energy_detect_power_down", A_STATUS, 32'h0000_0002);
    energy <= 1'b0;
    cyc(TMO - 5);
    chk("before_timeout", phy_en, 4'hD);
    cyc(15);
    chk("low_power", phy_en, 4'h0);
    rdchk("status_low", A_STATUS, 32'h0000_000A);
    // A pulse may already be under way; let it end so a whole one is measured
    n = 0;
    while (link_pulse === 1'b1 && n < GAP)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (link_pulse !== 1'b1 && n < 2 * GAP)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (link_pulse === 1'b1 && n < GAP)
    begin
      @(posedge clk);
      n++;
    end
    chk("pulse_len", 32'(n), 32'(LP_LEN_CYC));
    n = 0;
    while (link_pulse !== 1'b1 && n < 2 * GAP)
    begin
      @(posedge clk);
      n++;
    end
    chk("pulse_gap", 32'(n), 32'(GAP - LP_LEN_CYC));
    energy <= 1'b1;
    cyc(12);
    energy <= 1'b0;
    cyc(3);
    chk("short_energy", phy_en, 4'h0);
    energy <= 1'b1;
    cyc(16);
    chk("energy_wake", phy_en, 4'hD);
    // Reserved code is tried outside normal mode, where a fall-back to normal would show
    wr(A_PD_CTRL0, 32'h0000_0018);
    cyc(3);
    rdchk("code11_ignored", A_STATUS, 32'h0000_0002);
    wr(A_PD_CTRL0, 32'h0000_0000);
    cyc(3);
    chk("normal_again", {pll_en, mac_en, host_en, ed_only}, 4'hE);
  endtask

  task automatic t_softpd;
    wr(A_PORT_PD, 32'h0000_0015);
    wr(A_CLK_OUT, 32'h0000_0003);
    strap <= 4'hA;
    wr(A_PD_CTRL0, 32'h0000_0010);
    cyc(3);
    chk("softpd_enables", {pll_en, mac_en, host_en, ed_only, phy_en}, 8'h00);
    ticks("softpd_clk", 0);
    rdchk("bus_in_softpd", A_PORT_PD, 32'h0000_0015);
    rdchk("status_softpd", A_STATUS, 32'h0000_0004);
    wr(A_PD_CTRL0, 32'h0000_0000);
    cyc(3);
    rdchk("port_pd_default", A_PORT_PD, 32'h0000_0000);
    rdchk("clk_default", A_CLK_OUT, 32'h0000_0001);
    rdchk("strap_resampled", A_STRAP, 32'h0000_000A);
    rdchk("eee_from_strap", A_EEE_EN, 32'h0000_000A);
  endtask

  task automatic t_lpi;
    wr(A_EEE_EN, 32'h0000_001F);
    rdchk("no_port5_eee", A_EEE_EN, 32'h0000_000F);
    wr(A_EEE_EN, 32'h0000_0001);
    txr_cmd <= 4'h3;
    cyc(3);
    chk("lpi_tx_enter", {lpi_tx, lpi_rx}, 8'h10);
    txr_cmd <= 4'h0;
    rxi_cmd <= 4'h1;
    cyc(2);
    chk("lpi_swap", {lpi_tx, lpi_rx}, 8'h01);
    an_cmd <= 4'hE;
    cyc(2);
    chk("lpi_needs_an", lpi_rx, 4'h0);
  endtask

  initial
  begin
    rst     = 1'b1;
    hsel    = 1'b0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    haddr   = 32'h0000_0000;
    hwdata  = 32'h0000_0000;
    strap   = 4'h5;
    energy  = 1'b1;
    an_cmd  = 4'hF;
    txr_cmd = 4'h0;
    rxi_cmd = 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    t_reset;
    t_clk;
    t_energy_detect_power_down;
    t_softpd;
    t_lpi;
    end_sim;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim;
  end
endmodule
